// ---- design/cbt_target.v ----
`timescale 1ns/100ps
// Notes on behaviour
// R1: Bytes travel on eight shared two-way data lines; a host serves sixteen targets.
// R2: Data, phase and strobe are shared; select and acknowledge are per target.
// R3: Host addresses targets by a sixteen-bit mask; several bits broadcast.
// R4: Undriven strobe, phase and select lines read low at the target.
// R5: Host reads an undriven acknowledge line as high.
// R6: The target never starts a transfer itself.
// R7: Host runs one block transfer at a time.
// R8: The target's acknowledge paces each byte handshake.
// R9: A two-bit phase field tells the target how to treat each strobe.
// R10: Phase 0 carries the first byte and interrupts the microprocessor.
// R11: Phase 1 carries remaining outbound bytes.
// R12: Phase 2 returns bytes to the host only when a reply is asked.
// R13: Phase 3 with select asserted pulses the microprocessor reset.
// R14: Host sequences phases 0, 1, then 2, never backward.
// R15: Every transfer moves at least two bytes in total.
// R16: A padding byte is accepted and discarded by the target.
// R17: The first byte is the function code steering the transfer.
// R18: Host resets all targets through phase 3 before data transfers.
// R19: Host buffers bytes in transmit and receive queues.
// R20: An eight-bit two-way register sits between bus and microprocessor.
// R21: Host may route a periodic tick through as an interrupt.
// R22: Byte is captured on the strobe trailing edge, 0.8 us after data.
// R23: After the last outbound acknowledge, host moves to phase 2.
// R24: A broadcast byte counts only once every selected target acknowledges.
// R25: Host limits a transfer to 2048 bytes.
// R26: Host holds phase and select stable through each handshake.
// R27: Host signals completion after the last byte.
`include "cbt_map.vh"
module cbt_target #(
    parameter RESET_CYCLES = (`CBT_RESET_NS * `CBT_CLK_MHZ + 999) / 1000
) (
    input  wire       clk,
    input  wire       rstn,
    input  wire       select,       // R2
    input  wire [1:0] mode,
    input  wire       strobe,       // R2
    input  wire [7:0] bus_data_in,  // R1
    output reg  [7:0] bus_data_out,
    output wire       bus_data_oe,
    output reg        ack,          // R2
    output reg  [7:0] cpu_rx_data,
    output reg        cpu_rx_valid,
    output reg        cpu_rx_first,
    output reg        cpu_irq,
    input  wire       cpu_irq_clear,
    input  wire       cpu_rx_done,
    input  wire [7:0] cpu_tx_data,
    input  wire       cpu_tx_load,
    output reg        cpu_tx_taken,
    output reg        cpu_reset
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_ACK  = 2'h2;

    reg [1:0]  state;
    reg [1:0]  next_state;
    reg        strobe_d;
    reg        tx_full;
    reg        sending;
    reg [15:0] rst_cnt;
    wire       strobe_fall;
    wire       mode_reset;
    wire       take_byte;
    wire       take_out;
    wire       take_ret;
    wire       rx_release;
    wire       ack_release;
    wire       reset_start;

    // True when the phase field carries the given code.
    function is_mode(input [1:0] phase, input [1:0] code);
        begin
            is_mode = (phase == code); // R9
        end
    endfunction

    assign strobe_fall = strobe_d & ~strobe; // R22
    assign mode_reset  = select & is_mode(mode, `CBT_MODE_RESET); // R13
    // Only a host strobe with select can start a handshake.
    assign take_byte   = (state == ST_IDLE) & select & strobe_fall & ~is_mode(mode, `CBT_MODE_RESET); // R6
    assign take_out    = take_byte & ~is_mode(mode, `CBT_MODE_RETURN); // R11 R16
    assign take_ret    = take_byte & is_mode(mode, `CBT_MODE_RETURN) & tx_full; // R12
    assign rx_release  = (state == ST_WAIT) & cpu_rx_done; // R8
    assign ack_release = (state == ST_ACK) & (~strobe | ~select);
    assign reset_start = mode_reset & (rst_cnt == 16'h0000) & ~cpu_reset;

    // The pins stay driven until the host has taken the return byte with the acknowledge.
    assign bus_data_oe = select & is_mode(mode, `CBT_MODE_RETURN) & (tx_full | sending); // R12

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take_ret) begin
                    next_state = ST_ACK; // R8
                end else if (take_out) begin
                    next_state = ST_WAIT; // R11
                end
            end
            ST_WAIT: begin
                if (rx_release) begin
                    next_state = ST_ACK; // R8
                end
            end
            ST_ACK: begin
                if (ack_release) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (mode_reset) begin
            next_state = ST_IDLE; // R13
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // The idle level of the strobe is low, so no false edge follows reset.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strobe_d <= 1'b0; // R4
        end else begin
            strobe_d <= strobe;
        end
    end

    // In phases 0 and 1 the acknowledge waits for the microprocessor, so it sets the pace.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack <= 1'b0;
        end else if (mode_reset) begin
            ack <= 1'b0;
        end else if (take_ret || rx_release) begin
            ack <= 1'b1; // R8
        end else if (ack_release) begin
            ack <= 1'b0;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sending <= 1'b0;
        end else if (mode_reset || ack_release) begin
            sending <= 1'b0;
        end else if (take_ret) begin
            sending <= 1'b1; // R12
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_full <= 1'b0;
        end else if (cpu_tx_load) begin
            tx_full <= 1'b1; // R20
        end else if (mode_reset || take_ret) begin
            tx_full <= 1'b0; // R12
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_data_out <= 8'h00;
        end else if (cpu_tx_load) begin
            bus_data_out <= cpu_tx_data; // R20
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpu_tx_taken <= 1'b0;
        end else begin
            cpu_tx_taken <= take_ret; // R12
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpu_rx_data  <= 8'h00;
            cpu_rx_first <= 1'b0;
        end else if (take_out) begin
            cpu_rx_data  <= bus_data_in; // R20 R22
            cpu_rx_first <= is_mode(mode, `CBT_MODE_FIRST); // R17
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpu_rx_valid <= 1'b0;
        end else if (take_out) begin
            cpu_rx_valid <= 1'b1; // R16
        end else if (rx_release || mode_reset) begin
            cpu_rx_valid <= 1'b0;
        end
    end

    // A new function code wins over a clear in the same cycle.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpu_irq <= 1'b0;
        end else if (take_out && is_mode(mode, `CBT_MODE_FIRST)) begin
            cpu_irq <= 1'b1; // R10
        end else if (cpu_irq_clear || mode_reset) begin
            cpu_irq <= 1'b0;
        end
    end

    // Reset pulse of fixed length toward the microprocessor.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_cnt   <= 16'h0000;
            cpu_reset <= 1'b0;
        end else if (reset_start) begin
            rst_cnt   <= RESET_CYCLES[15:0]; // R13
            cpu_reset <= 1'b1;
        end else if (rst_cnt != 16'h0000) begin
            rst_cnt <= rst_cnt - 16'h0001;
            if (rst_cnt == 16'h0001) begin
                cpu_reset <= 1'b0;
            end
        end
    end
endmodule // cbt_target

// ---- design/cbt_map.vh ----
`ifndef CBT_MAP_VH
`define CBT_MAP_VH
`define CBT_MODE_FIRST    2'h0
`define CBT_MODE_OUT      2'h1
`define CBT_MODE_RETURN   2'h2
`define CBT_MODE_RESET    2'h3
`define CBT_CLK_MHZ       40
`define CBT_CAPTURE_NS    800
`define CBT_ACK_NS        2000
`define CBT_RESET_NS      10000
`endif

// ---- test/cbt_target_monitor.sv ----
`timescale 1ns/100ps
module cbt_target_monitor(input logic clk, rstn, select, ack, bus_data_oe, cpu_rx_done,
    input logic [1:0] mode, input logic cpu_rx_valid, cpu_rx_first, cpu_irq, cpu_reset, cpu_tx_taken);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_oe_sel: assert property (bus_data_oe |-> select && mode == 2'h2) else $error("oe");
    a_ack_done: assert property ($rose(ack) && mode != 2'h2 |-> $past(cpu_rx_done)) else $error("ack");
    a_irq_first: assert property ($rose(cpu_irq) |-> cpu_rx_first && cpu_rx_valid) else $error("irq");
    a_rst_len: assert property ($rose(cpu_reset) |-> cpu_reset[*4] ##1 !cpu_reset) else $error("rlen");
    a_rst_why: assert property ($rose(cpu_reset) |-> $past(select && mode == 2'h3)) else $error("rwhy");
    a_rx_sel: assert property ($rose(cpu_rx_valid) |-> $past(select)) else $error("rxsel");
    a_first_m0: assert property ($rose(cpu_rx_valid) |-> cpu_rx_first == ($past(mode) == 2'h0)) else $error("fc");
    a_taken_one: assert property (cpu_tx_taken |=> !cpu_tx_taken) else $error("tk");
endmodule // cbt_target_monitor
bind cbt_target cbt_target_monitor i_mon(.*);

// ---- test/cbt_host_model.sv ----
`timescale 1ns/100ps
module cbt_host_model(input logic clk, ack, input logic [7:0] rdata,
    output logic select = 0, strobe = 0, output logic [1:0] mode = 0, output logic [7:0] data = 0);
    // One byte handshake per call for phases 0 to 2; phase 3 drives select, phase and data, with no strobe.
    task automatic xfer(input logic [1:0] m, input logic [7:0] d, output logic ok, output logic [7:0] rd);
        ok = 0;
        rd = 8'h00;
        @(posedge clk);
        {select, mode, data, strobe} <= {1'b1, m, d, m != 2'h3};
        if (m != 2'h3) begin
            repeat (32) @(posedge clk);
            strobe <= 0;
            repeat (40) begin
                @(posedge clk);
                if (ok && ack === 1'b0) break;
                if (!ok && ack === 1'b1) {ok, rd} = {1'b1, rdata};
            end
        end
        @(posedge clk) {select, data} <= {1'b0, ~d};
    endtask
endmodule // cbt_host_model

// ---- test/tb_cbt_target.sv ----
`timescale 1ns/100ps
module tb_cbt_target;
    logic clk = 0, rstn = 0, sel, stb, clr = 0, done = 0, load = 0, ack, oe, val, fst, irq, tk, cr, ok;
    logic [1:0] md;
    logic [7:0] hd, dout, rx, txd = 8'h00, rd;
    wire  [7:0] bin = oe ? dout : hd;
    int fails = 0, checks_done = 0, rc = 0, tc = 0;
    initial forever #12.5 clk = ~clk;
    cbt_host_model h(.clk(clk), .ack(ack), .rdata(bin), .select(sel), .strobe(stb), .mode(md), .data(hd));
    cbt_target #(.RESET_CYCLES(4)) i_dut(.clk(clk), .rstn(rstn), .select(sel), .mode(md), .strobe(stb),
        .bus_data_in(bin), .bus_data_out(dout), .bus_data_oe(oe), .ack(ack), .cpu_rx_data(rx), .cpu_rx_valid(val),
        .cpu_rx_first(fst), .cpu_irq(irq), .cpu_irq_clear(clr), .cpu_rx_done(done), .cpu_tx_data(txd),
        .cpu_tx_load(load), .cpu_tx_taken(tk), .cpu_reset(cr));
    always @(posedge clk) begin
        done <= val & ~done;
        rc <= rc + cr;
        tc <= tc + tk;
    end
    task chk(input string n, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task end_sim;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task t_reset;
        h.xfer(2'h3, 8'h00, ok, rd);
        repeat (8) @(posedge clk);
        chk("rst", 8'h04, 8'(rc));
        $display("t_reset done");
    endtask
    task t_write;
        h.xfer(2'h0, 8'ha5, ok, rd);
        chk("ack", 1, ok);
        chk("rx", 8'ha5, rx);
        chk("fst", 1, fst);
        chk("irq", 1, irq);
        @(posedge clk) clr <= 1;
        @(posedge clk) clr <= 0;
        h.xfer(2'h1, 8'h3c, ok, rd);
        chk("rx", 8'h3c, rx);
        chk("fst", 0, fst);
        chk("irq", 0, irq);
        $display("t_write done");
    endtask
    task t_ret;
        @(posedge clk) {txd, load} <= {8'h5a, 1'b1};
        @(posedge clk) load <= 0;
        h.xfer(2'h2, 8'h00, ok, rd);
        chk("rd", 8'h5a, rd);
        chk("tk", 1, 8'(tc));
        h.xfer(2'h2, 8'h00, ok, rd);
        chk("noack", 0, ok);
        $display("t_ret done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1;
        t_reset;
        t_write;
        t_ret;
        end_sim;
    end
    initial begin
        #50000;
        fails++;
        end_sim;
    end
endmodule // tb_cbt_target
